// [lmr_receiver.sv]
// Receive message controller with register port and message buffer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lmr_regs.svh"
module lmr_receiver (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Overhead link
   lmr_link_if.receiver link,
   // Register port
   input wire logic [15:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Interrupt
   output logic irq_out
);
   lmr_pkg::lmr_rx_state_t st_q, st_d;
   logic [7:0] mem [0:89];
   logic [7:0] sh_q, sh_d, db_q, db_d, rdata_q, rdata_d, len_q, len_d;
   logic [2:0] ones_q, ones_d, bc_q, bc_d, ist_q, ist_d, ien_q, ien_d;
   logic [6:0] idx_q, idx_d, wp_q, wp_d, cp_q, cp_d, rp_q, rp_d, cnt_q, cnt_d, fb_q, fb_d;
   logic [15:0] crc_q, crc_d, crc_nx;
   logic en_q, en_d, var_q, var_d, flag_q, flag_d, eom_q, eom_d, fcse_q, fcse_d;
   logic abort_q, abort_d, hbad_q, hbad_d, crcok_q, crcok_d;
   logic bit_v, is_flag, stuffed, byte_done, mem_we, pop, done_ev, drop_ev, fcs_ev;
   logic [6:0] pay;
   logic [7:0] nbyte;

   lmr_crc16 u_crc (
      .crc_in(crc_q),
      .bit_in(link.oh_bit),
      .crc_out(crc_nx)
   );

   function automatic logic [6:0] inc90(input logic [6:0] p);
      inc90 = (p == `LMR_BUF_LAST) ? 7'h00 : p + 7'h01;
   endfunction

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      db_d = db_q;
      ones_d = ones_q;
      bc_d = bc_q;
      idx_d = idx_q;
      wp_d = wp_q;
      cp_d = cp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      fb_d = fb_q;
      crc_d = crc_q;
      crcok_d = crcok_q;
      hbad_d = hbad_q;
      en_d = en_q;
      var_d = var_q;
      flag_d = flag_q;
      eom_d = eom_q;
      fcse_d = fcse_q;
      abort_d = abort_q;
      len_d = len_q;
      ien_d = ien_q;
      rdata_d = 8'h00;
      mem_we = 1'b0;
      done_ev = 1'b0;
      drop_ev = 1'b0;
      fcs_ev = 1'b0;
      pop = 1'b0;
      byte_done = 1'b0;
      nbyte = {link.oh_bit, db_q[7:1]};
      pay = idx_q - `LMR_OVERHEAD_BYTES;
      bit_v = link.oh_valid && en_q;
      is_flag = ({link.oh_bit, sh_q[7:1]} == `LMR_FLAG);
      stuffed = (ones_q == 3'h5) && !link.oh_bit;
      if (bit_v) begin
         sh_d = {link.oh_bit, sh_q[7:1]};
         ones_d = link.oh_bit ? ((ones_q == 3'h7) ? ones_q : ones_q + 3'h1) : 3'h0;
         if (is_flag) begin
            flag_d = 1'b1;
            if (st_q == lmr_pkg::RX_FRAME && idx_q != 7'h00) begin
               if (bc_q == 3'h7 && idx_q >= `LMR_OVERHEAD_BYTES &&
                   (var_q || (!hbad_q && (pay == `LMR_STD_PAYLOAD_A ||
                                          pay == `LMR_STD_PAYLOAD_B)))) begin
                  cp_d = (wp_q < 7'h02) ? wp_q + 7'h58 : wp_q - 7'h02;
                  cnt_d = cnt_q + fb_q - 7'h02;
                  wp_d = cp_d;
                  len_d = {1'b0, idx_q - 7'h02};
                  done_ev = 1'b1;
                  eom_d = 1'b1;
                  fcse_d = !crcok_q;
                  fcs_ev = !crcok_q;
               end else begin
                  wp_d = cp_q;
                  drop_ev = 1'b1;
               end
            end
            st_d = lmr_pkg::RX_FRAME;
            idx_d = 7'h00;
            bc_d = 3'h0;
            fb_d = 7'h00;
            hbad_d = 1'b0;
            crc_d = `LMR_CRC_INIT;
         end else if (ones_q == 3'h6 && link.oh_bit) begin
            abort_d = 1'b1;
            flag_d = 1'b0;
            if (st_q == lmr_pkg::RX_FRAME && idx_q != 7'h00) begin
               drop_ev = 1'b1;
            end
            st_d = lmr_pkg::RX_HUNT;
            wp_d = cp_q;
         end else if (st_q == lmr_pkg::RX_FRAME && !stuffed) begin
            db_d = nbyte;
            bc_d = bc_q + 3'h1;
            crc_d = crc_nx;
            if (bc_q == 3'h7) begin
               byte_done = 1'b1;
               flag_d = 1'b0;
               crcok_d = (crc_nx == `LMR_CRC_GOOD);
               if ((idx_q == 7'h00 && nbyte != `LMR_ADDR1_A && nbyte != `LMR_ADDR1_B) ||
                   (idx_q == 7'h01 && nbyte != `LMR_ADDR2) ||
                   (idx_q == 7'h02 && nbyte != `LMR_CONTROL)) begin
                  hbad_d = 1'b1;
               end
               if (idx_q == `LMR_MAX_PAYLOAD + `LMR_OVERHEAD_BYTES ||
                   cnt_q + fb_q == `LMR_BUF_BYTES) begin
                  st_d = lmr_pkg::RX_HUNT;
                  wp_d = cp_q;
                  drop_ev = 1'b1;
               end else begin
                  mem_we = 1'b1;
                  wp_d = inc90(wp_q);
                  fb_d = fb_q + 7'h01;
                  idx_d = idx_q + 7'h01;
               end
            end
         end
      end
      if (!en_q) begin
         st_d = lmr_pkg::RX_HUNT;
         wp_d = cp_q;
         flag_d = 1'b0;
      end
      if (wr_in && addr_in == `LMR_ADDR_CTRL) begin
         en_d = wdata_in[`LMR_CTRL_EN_BIT];
         var_d = wdata_in[`LMR_CTRL_VAR_BIT];
      end
      if (wr_in && addr_in == `LMR_ADDR_IEN) begin
         ien_d = wdata_in[2:0];
      end
      if (rd_in) begin
         unique case (addr_in)
            `LMR_ADDR_CTRL: rdata_d = {1'b0, var_q, 3'h0, en_q, 2'h0};
            `LMR_ADDR_STAT: begin
               rdata_d = {1'b0, abort_q, 3'h0, fcse_q, eom_q, flag_q};
               eom_d = done_ev;
               // Abort in the same cycle survives the read
               abort_d = bit_v && ones_q == 3'h6 && link.oh_bit;
            end
            `LMR_ADDR_ISTAT: rdata_d = {5'h00, ist_q};
            `LMR_ADDR_IEN: rdata_d = {5'h00, ien_q};
            `LMR_ADDR_LEN: rdata_d = len_q;
            `LMR_ADDR_FILL: rdata_d = {1'b0, cnt_q};
            `LMR_ADDR_BUF: begin
               if (cnt_q != 7'h00) begin
                  rdata_d = mem[rp_q];
                  pop = 1'b1;
                  rp_d = inc90(rp_q);
               end
            end
            default: rdata_d = 8'h00;
         endcase
      end
      cnt_d = cnt_d - {6'h00, pop};
      ist_d = ist_q & ~((wr_in && addr_in == `LMR_ADDR_ICLR) ? wdata_in[2:0] : 3'h0);
      ist_d = ist_d | {drop_ev, fcs_ev, done_ev};
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_q <= lmr_pkg::RX_HUNT;
         sh_q <= 8'h00;
         db_q <= 8'h00;
         ones_q <= 3'h0;
         bc_q <= 3'h0;
         idx_q <= 7'h00;
         wp_q <= 7'h00;
         cp_q <= 7'h00;
         rp_q <= 7'h00;
         cnt_q <= 7'h00;
         fb_q <= 7'h00;
         crc_q <= `LMR_CRC_INIT;
         crcok_q <= 1'b0;
         hbad_q <= 1'b0;
         en_q <= 1'b0;
         var_q <= 1'b0;
         flag_q <= 1'b0;
         eom_q <= 1'b0;
         fcse_q <= 1'b0;
         abort_q <= 1'b0;
         len_q <= 8'h00;
         ien_q <= 3'h0;
         ist_q <= 3'h0;
         rdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         db_q <= db_d;
         ones_q <= ones_d;
         bc_q <= bc_d;
         idx_q <= idx_d;
         wp_q <= wp_d;
         cp_q <= cp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         fb_q <= fb_d;
         crc_q <= crc_d;
         crcok_q <= crcok_d;
         hbad_q <= hbad_d;
         en_q <= en_d;
         var_q <= var_d;
         flag_q <= flag_d;
         eom_q <= eom_d;
         fcse_q <= fcse_d;
         abort_q <= abort_d;
         len_q <= len_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
         rdata_q <= rdata_d;
      end
   end

   // Message storage
   always_ff @(posedge core_clk_in) begin
      if (mem_we) begin
         mem[wp_q] <= nbyte;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out = |(ist_q & ien_q);
endmodule
`default_nettype wire

// [lmr_regs.svh]
// Register map, field positions and timing counts of the message receiver
// Overview of operation
// - Message bits come only from overhead bit
// - 90-byte message FIFO behind one port
// - Accept messages up to 82 bytes
// - Standard 76/82 or variable-length payload modes
// - Byte 0x7e delimits every frame
// - Idle link carries back-to-back flags
// - Flag, two address, control, payload, FCS, flag
// - Standard headers 0x3c/0x3e, 0x01, 0x03
// - Sender sets service point identifier 001111
// - Sender sets endpoint identifier to zero
// - Control octet 0x03, unnumbered frames only
// - FCS uses x16+x12+x5+1 over header, payload
// - Receiver recomputes and checks the FCS
// - Extract only while enable bit 2 set
// - Flag-present status bit 0 while flags
// - Interrupt when a new message completes
`ifndef LMR_REGS_SVH
`define LMR_REGS_SVH
`define LMR_ADDR_CTRL 16'h1118
`define LMR_ADDR_STAT 16'h1119
`define LMR_ADDR_ISTAT 16'h111a
`define LMR_ADDR_ICLR 16'h111b
`define LMR_ADDR_IEN 16'h111c
`define LMR_ADDR_LEN 16'h111d
`define LMR_ADDR_FILL 16'h111e
`define LMR_ADDR_BUF 16'h11c0
`define LMR_CTRL_EN_BIT 2
`define LMR_CTRL_VAR_BIT 6
`define LMR_STAT_FLAG_BIT 0
`define LMR_STAT_EOM_BIT 1
`define LMR_STAT_FCS_BIT 2
`define LMR_STAT_ABORT_BIT 6
`define LMR_INT_DONE_BIT 0
`define LMR_INT_FCS_BIT 1
`define LMR_INT_DROP_BIT 2
`define LMR_BUF_BYTES 7'h5a
`define LMR_BUF_LAST 7'h59
`define LMR_MAX_PAYLOAD 7'h52
`define LMR_STD_PAYLOAD_A 7'h4c
`define LMR_STD_PAYLOAD_B 7'h52
`define LMR_OVERHEAD_BYTES 7'h05
`define LMR_FLAG 8'h7e
`define LMR_ADDR1_A 8'h3c
`define LMR_ADDR1_B 8'h3e
`define LMR_ADDR2 8'h01
`define LMR_CONTROL 8'h03
`define LMR_CRC_INIT 16'hffff
`define LMR_CRC_POLY 16'h8408
`define LMR_CRC_GOOD 16'hf0b8
`define LMR_FRAME_NS 44690
`define LMR_CLK_NS 10
`define LMR_FRAME_CYCLES (`LMR_FRAME_NS / `LMR_CLK_NS)
`endif

// [lmr_pkg.sv]
// Types shared by the two link ends
package lmr_pkg;
   typedef enum logic [0:0] {RX_HUNT, RX_FRAME} lmr_rx_state_t;
   typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_FCS} lmr_tx_state_t;
endpackage

// [lmr_link_if.sv]
// Overhead-bit link between the remote sender and the receiver
`timescale 1ns/100ps
`default_nettype none
interface lmr_link_if;
   logic oh_bit;
   logic oh_valid;
   modport sender(output oh_bit, output oh_valid);
   modport receiver(input oh_bit, input oh_valid);
endinterface
`default_nettype wire

// [lmr_crc16.sv]
// One-bit step of the frame check value
`timescale 1ns/100ps
`default_nettype none
`include "lmr_regs.svh"
module lmr_crc16 (
   // Current value and serial bit
   input wire logic [15:0] crc_in,
   input wire logic bit_in,
   // Next value
   output logic [15:0] crc_out
);
   assign crc_out = {1'b0, crc_in[15:1]} ^ ((crc_in[0] ^ bit_in) ? `LMR_CRC_POLY : 16'h0000);
endmodule
`default_nettype wire

// [lmr_sender.sv]
// Remote sender: flags, framing, stuffing and check value on the overhead bit
`timescale 1ns/100ps
`default_nettype none
`include "lmr_regs.svh"
module lmr_sender #(
   parameter int FRAME_CYCLES = `LMR_FRAME_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Overhead link
   lmr_link_if.sender link,
   // Payload source
   input wire logic [7:0] msg_data_in,
   input wire logic msg_valid_in,
   input wire logic msg_last_in,
   output logic msg_ready_out
);
   lmr_pkg::lmr_tx_state_t st_q, st_d;
   logic [12:0] tc_q, tc_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] bc_q, bc_d, ones_q, ones_d;
   logic [1:0] idx_q, idx_d;
   logic [15:0] crc_q, crc_d, crc_nx;
   logic last_q, last_d, hi_q, hi_d, ob_q, ob_d, ov_q, ov_d, tick, take;

   lmr_crc16 u_crc (
      .crc_in(crc_q),
      .bit_in(sh_q[0]),
      .crc_out(crc_nx)
   );

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bc_d = bc_q;
      ones_d = ones_q;
      idx_d = idx_q;
      crc_d = crc_q;
      last_d = last_q;
      hi_d = hi_q;
      ob_d = ob_q;
      ov_d = 1'b0;
      take = 1'b0;
      tick = (tc_q == 13'(FRAME_CYCLES - 1));
      tc_d = tick ? 13'h0000 : tc_q + 13'h0001;
      if (tick) begin
         ov_d = 1'b1;
         if (ones_q == 3'h5) begin
            ob_d = 1'b0;
            ones_d = 3'h0;
         end else begin
            ob_d = sh_q[0];
            ones_d = (st_q == lmr_pkg::TX_FLAG || !sh_q[0]) ? 3'h0 : ones_q + 3'h1;
            if (st_q == lmr_pkg::TX_DATA) begin
               crc_d = crc_nx;
            end
            sh_d = {1'b0, sh_q[7:1]};
            bc_d = bc_q + 3'h1;
            if (bc_q == 3'h7) begin
               unique case (st_q)
                  lmr_pkg::TX_FLAG: begin
                     sh_d = `LMR_FLAG;
                     if (msg_valid_in) begin
                        st_d = lmr_pkg::TX_DATA;
                        sh_d = `LMR_ADDR1_A;
                        idx_d = 2'h1;
                        crc_d = `LMR_CRC_INIT;
                        last_d = 1'b0;
                     end
                  end
                  lmr_pkg::TX_DATA: begin
                     if (idx_q == 2'h1) begin
                        sh_d = `LMR_ADDR2;
                        idx_d = 2'h2;
                     end else if (idx_q == 2'h2) begin
                        sh_d = `LMR_CONTROL;
                        idx_d = 2'h3;
                     end else if (!last_q && msg_valid_in) begin
                        sh_d = msg_data_in;
                        take = 1'b1;
                        last_d = msg_last_in;
                     end else begin
                        st_d = lmr_pkg::TX_FCS;
                        sh_d = ~crc_nx[7:0];
                        hi_d = 1'b1;
                     end
                  end
                  lmr_pkg::TX_FCS: begin
                     if (hi_q) begin
                        sh_d = ~crc_q[15:8];
                        hi_d = 1'b0;
                     end else begin
                        st_d = lmr_pkg::TX_FLAG;
                        sh_d = `LMR_FLAG;
                     end
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_q <= lmr_pkg::TX_FLAG;
         tc_q <= 13'h0000;
         sh_q <= `LMR_FLAG;
         bc_q <= 3'h0;
         ones_q <= 3'h0;
         idx_q <= 2'h0;
         crc_q <= `LMR_CRC_INIT;
         last_q <= 1'b0;
         hi_q <= 1'b0;
         ob_q <= 1'b0;
         ov_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tc_q <= tc_d;
         sh_q <= sh_d;
         bc_q <= bc_d;
         ones_q <= ones_d;
         idx_q <= idx_d;
         crc_q <= crc_d;
         last_q <= last_d;
         hi_q <= hi_d;
         ob_q <= ob_d;
         ov_q <= ov_d;
      end
   end

   assign link.oh_bit = ob_q;
   assign link.oh_valid = ov_q;
   assign msg_ready_out = take;
endmodule
`default_nettype wire

// [lmr_link_props.sv]
// Checker on the overhead link between sender and receiver
`timescale 1ns/100ps
`default_nettype none
`include "lmr_regs.svh"
module lmr_link_props #(
   parameter int FRAME_CYCLES = 4
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Link signals
   input wire logic oh_bit,
   input wire logic oh_valid
);
   logic [15:0] gap_q, gap_d;
   logic [2:0] run_q, run_d;
   logic [3:0] nb_q, nb_d;
   logic [7:0] sh_q, sh_d, flag_c;
   logic [9:0] db_q, db_d;
   logic seen_q, seen_d, fend;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   assign flag_c = `LMR_FLAG;
   assign fend = oh_valid && !oh_bit && run_q == 3'h6;
   // Bit history, runs of ones, destuffed bit count
   always_comb begin
      gap_d = oh_valid ? 16'h0 : gap_q + 16'h1;
      seen_d = seen_q | oh_valid;
      run_d = run_q;
      nb_d = nb_q;
      sh_d = sh_q;
      db_d = db_q;
      if (oh_valid) begin
         run_d = (oh_bit && run_q != 3'h7) ? run_q + 3'h1 : (oh_bit ? run_q : 3'h0);
         nb_d = (nb_q == 4'hf) ? nb_q : nb_q + 4'h1;
         sh_d = {oh_bit, sh_q[7:1]};
         if (fend) begin
            db_d = 10'h0;
         end else if ((oh_bit || run_q != 3'h5) && db_q != 10'h3ff) begin
            db_d = db_q + 10'h1;
         end
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gap_q <= 16'h0;
         seen_q <= 1'b0;
         run_q <= 3'h0;
         nb_q <= 4'h0;
         sh_q <= 8'h0;
         db_q <= 10'h0;
      end else begin
         gap_q <= gap_d;
         seen_q <= seen_d;
         run_q <= run_d;
         nb_q <= nb_d;
         sh_q <= sh_d;
         db_q <= db_d;
      end
   end
   valid_pulse_a: assert property (oh_valid |=> !oh_valid)
      else $error("strobe longer than one cycle");
   frame_period_a: assert property (oh_valid && seen_q |-> gap_q == 16'(FRAME_CYCLES - 1))
      else $error("strobe period wrong");
   start_delay_a: assert property (oh_valid && !seen_q |-> gap_q >= 16'(FRAME_CYCLES - 2))
      else $error("first strobe too early");
   reset_quiet_a: assert property ($fell(sys_rst_in) |-> !oh_valid && !oh_bit)
      else $error("link not quiet after reset");
   first_flag_a: assert property (oh_valid && nb_q < 4'h8 |-> oh_bit == flag_c[nb_q[2:0]])
      else $error("link does not open with a flag");
   stuff_run_a: assert property (oh_valid && run_q == 3'h6 |-> !oh_bit)
      else $error("seven ones on the link");
   flag_shape_a: assert property (fend |-> sh_q[7:2] == 6'h3f && !sh_q[1])
      else $error("malformed flag");
   byte_align_a: assert property (fend |-> db_q[2:0] == 3'h7)
      else $error("frame not whole bytes");
   frame_size_a: assert property (fend |-> db_q <= 10'h2bf)
      else $error("frame too long");
endmodule
`default_nettype wire

// [lmr_receiver_tb.sv]
// Bench: sender and receiver joined, plus a faulty second link
`timescale 1ns/100ps
`default_nettype none
`include "lmr_regs.svh"
module lmr_receiver_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0;
   logic [7:0] wdata = 8'h0;
   logic [7:0] md = 8'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic mval = 1'b0;
   logic mlast = 1'b0;
   logic [7:0] rdata, rdata2, v;
   logic irq, irq2, mrdy;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] ra [6] = '{`LMR_ADDR_CTRL, `LMR_ADDR_STAT, `LMR_ADDR_ISTAT,
      `LMR_ADDR_IEN, `LMR_ADDR_FILL, 16'h1100};
   logic [7:0] fb [9] = '{8'h7e, 8'h7e, 8'h3c, 8'h01, 8'h03, 8'h55, 8'h00, 8'h00, 8'h7e};
   lmr_link_if lk();
   lmr_link_if lk2();
   always #5 clk = ~clk;
   lmr_sender #(.FRAME_CYCLES(4)) i_lmr_sender (.core_clk_in(clk), .sys_rst_in(rst),
      .link(lk.sender), .msg_data_in(md), .msg_valid_in(mval), .msg_last_in(mlast),
      .msg_ready_out(mrdy));
   lmr_receiver i_lmr_receiver (.core_clk_in(clk), .sys_rst_in(rst), .link(lk.receiver),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .irq_out(irq));
   lmr_receiver i_lmr_receiver_b (.core_clk_in(clk), .sys_rst_in(rst), .link(lk2.receiver),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata2),
      .irq_out(irq2));
   lmr_link_props #(.FRAME_CYCLES(4)) i_lmr_link_props (.core_clk_in(clk),
      .sys_rst_in(rst), .oh_bit(lk.oh_bit), .oh_valid(lk.oh_valid));
   function automatic logic [7:0] pay(input int k);
      return 8'(k * 37 + 240);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [15:0] a, input bit s);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = s ? rdata2 : rdata;
   endtask
   // Read until masked bits show, bounded
   task automatic poll(input logic [15:0] a, input logic [7:0] m, input bit s);
      int t;
      t = 0;
      do begin
         rreg(a, s);
         t++;
      end while ((v & m) == 8'h0 && t < 3000);
      chk(v & m, m);
   endtask
   // Payload bytes into the sender
   task automatic send(input int n);
      int t;
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         md <= pay(k);
         mlast <= (k == n - 1);
         mval <= 1'b1;
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (!mrdy && t < 4000);
      end
      @(posedge clk);
      mval <= 1'b0;
   endtask
   // Completed message: flags, length, buffer contents
   task automatic take(input int n, input logic ie);
      poll(`LMR_ADDR_ISTAT, 8'h01, 1'b0);
      chk({7'h0, irq}, {7'h0, ie});
      rreg(`LMR_ADDR_STAT, 1'b0);
      chk(v & 8'h06, 8'h02);
      rreg(`LMR_ADDR_LEN, 1'b0);
      chk(v, 8'(n + 3));
      rreg(`LMR_ADDR_FILL, 1'b0);
      chk(v, 8'(n + 3));
      for (int k = 0; k < n + 3; k++) begin
         rreg(`LMR_ADDR_BUF, 1'b0);
         chk(v, k == 0 ? `LMR_ADDR1_A : k == 1 ? `LMR_ADDR2 : k == 2 ? `LMR_CONTROL : pay(k - 3));
      end
      rreg(`LMR_ADDR_BUF, 1'b0);
      chk(v, 8'h00);
      wreg(`LMR_ADDR_ICLR, 8'h07);
   endtask
   // Faulty far end: bits go out unstuffed, so 0xff makes an abort
   task automatic raw(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         lk2.oh_valid <= 1'b1;
         lk2.oh_bit <= b[i];
         @(posedge clk);
         lk2.oh_valid <= 1'b0;
         lk2.oh_bit <= ~b[i];
         repeat (2) @(posedge clk);
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      lk2.oh_bit = 1'b0;
      lk2.oh_valid = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i]) begin
         rreg(ra[i], 1'b0);
         chk(v, 8'h00);
      end
      chk({7'h0, irq}, 8'h00);
      wreg(`LMR_ADDR_IEN, 8'h07);
      wreg(`LMR_ADDR_CTRL, 8'h44);
      poll(`LMR_ADDR_STAT, 8'h01, 1'b0);
      send(3);
      take(3, 1'b1);
      rreg(`LMR_ADDR_ISTAT, 1'b0);
      chk(v, 8'h00);
      chk({7'h0, irq}, 8'h00);
      send(82);
      take(82, 1'b1);
      raw(8'h7e);
      repeat (88) raw(8'h55);
      raw(8'h7e);
      poll(`LMR_ADDR_ISTAT, 8'h04, 1'b1);
      rreg(`LMR_ADDR_FILL, 1'b1);
      chk(v, 8'h00);
      wreg(`LMR_ADDR_ICLR, 8'h07);
      wreg(`LMR_ADDR_CTRL, 8'h04);
      send(76);
      take(76, 1'b1);
      send(10);
      poll(`LMR_ADDR_ISTAT, 8'h04, 1'b0);
      wreg(`LMR_ADDR_ICLR, 8'h07);
      wreg(`LMR_ADDR_IEN, 8'h00);
      send(82);
      take(82, 1'b0);
      wreg(`LMR_ADDR_CTRL, 8'h00);
      send(3);
      repeat (400) @(posedge clk);
      rreg(`LMR_ADDR_ISTAT, 1'b0);
      chk(v, 8'h00);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(`LMR_ADDR_CTRL, 1'b0);
      chk(v, 8'h00);
      wreg(`LMR_ADDR_CTRL, 8'h44);
      wreg(`LMR_ADDR_IEN, 8'h02);
      foreach (fb[i]) raw(fb[i]);
      poll(`LMR_ADDR_ISTAT, 8'h02, 1'b1);
      chk({7'h0, irq2}, 8'h01);
      rreg(`LMR_ADDR_STAT, 1'b1);
      chk(v & 8'h04, 8'h04);
      raw(8'h3c);
      raw(8'hff);
      rreg(`LMR_ADDR_STAT, 1'b1);
      chk(v & 8'h40, 8'h40);
      rreg(`LMR_ADDR_ISTAT, 1'b1);
      chk(v & 8'h04, 8'h04);
      close_out();
   end
endmodule
`default_nettype wire
